//--- core/l3rr_way_reserve.sv
// Cache way reservation: config registers and allocation way steering
`timescale 1ns/100ps
module l3rr_way_reserve
	import l3rr_pkg::*;
(
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire logic               msrWrEn,
	input  wire logic               msrRdEn,
	input  wire logic [31:0]        msrAddr,
	input  wire logic [63:0]        msrWrData,
	output logic      [63:0]        msrRdData,
	output logic                    msrRdValid,
	output logic                    msrFault,
	input  wire logic               reqValid,
	input  wire logic [PA_BITS-1:0] reqAddr,
	input  wire logic               reqCacheable,
	input  wire logic               reqEncrypted,
	input  wire logic [WAYS-1:0]    reqQosMask,
	output logic                    allocValid,
	output logic      [WAYS-1:0]    allocWays,
	output logic                    allocInRange,
	output logic                    reserveEnabled,
	output logic      [WAYS-1:0]    reservedWayBits
);
	l3rr_state_type r;
	l3rr_state_type r_nxt;
	l3rr_sel_type   sel;
	logic           mbzBad;

	l3rr_cfg_if cfgIf ();

	// One configuration per cache instance, private to this block
	assign cfgIf.en        = r.en;
	assign cfgIf.low       = r.low;
	assign cfgIf.high      = r.high;
	assign cfgIf.ways      = r.ways;
	assign cfgIf.addrField = reqAddr[PA_BITS-1:PAGE_LSB];
	assign cfgIf.encrypted = reqEncrypted;
	assign cfgIf.cacheable = reqCacheable;
	assign cfgIf.qosMask   = reqQosMask;

	l3rr_range_cmp u_cmp (
		.cfg (cfgIf.cmp)
	);

	l3rr_way_filter u_filt (
		.cfg (cfgIf.filt)
	);

	always_comb begin
		case (msrAddr)
			MSR_LOW_BOUND:  sel = SEL_LOW;
			MSR_HIGH_BOUND: sel = SEL_HIGH;
			MSR_WAY_SELECT: sel = SEL_WAYS;
			default:        sel = SEL_NONE;
		endcase
	end

	always_comb begin
		case (sel)
			SEL_LOW:  mbzBad = |(msrWrData & LOW_MBZ_MASK);
			SEL_HIGH: mbzBad = |(msrWrData & HIGH_MBZ_MASK);
			SEL_WAYS: mbzBad = |(msrWrData & WAYS_MBZ_MASK);
			default:  mbzBad = 1'b1;
		endcase
	end

	always_comb begin
		r_nxt         = r;
		r_nxt.rdValid = 1'b0;
		r_nxt.fault   = 1'b0;
		if (msrWrEn) begin
			// Writes with reserved bits set, or to unknown numbers, fault
			if (mbzBad) begin
				r_nxt.fault = 1'b1;
			end else begin
				case (sel)
					SEL_LOW: begin
						r_nxt.low = msrWrData[PA_BITS-1:PAGE_LSB];
					end
					SEL_HIGH: begin
						r_nxt.high = msrWrData[PA_BITS-1:PAGE_LSB];
						r_nxt.en   = msrWrData[EN_BIT];
					end
					SEL_WAYS: begin
						r_nxt.ways = msrWrData[WAYS-1:0];
					end
					default: begin
						r_nxt.fault = 1'b1;
					end
				endcase
			end
		end else if (msrRdEn) begin
			r_nxt.rdData = '0;
			case (sel)
				SEL_LOW: begin
					r_nxt.rdData[PA_BITS-1:PAGE_LSB] = r.low;
					r_nxt.rdValid = 1'b1;
				end
				SEL_HIGH: begin
					r_nxt.rdData[PA_BITS-1:PAGE_LSB] = r.high;
					r_nxt.rdData[EN_BIT] = r.en;
					r_nxt.rdValid = 1'b1;
				end
				SEL_WAYS: begin
					r_nxt.rdData[WAYS-1:0] = r.ways;
					r_nxt.rdValid = 1'b1;
				end
				default: begin
					r_nxt.fault = 1'b1;
				end
			endcase
		end
		// Allocation decisions only follow a real access, never a config write
		r_nxt.allocValid = reqValid;
		if (reqValid) begin
			r_nxt.allocWays    = cfgIf.allowWays;
			r_nxt.allocInRange = cfgIf.inRange && reqCacheable;
		end else begin
			r_nxt.allocWays    = NO_WAYS;
			r_nxt.allocInRange = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			r <= '{low: BOUND_RESET, high: BOUND_RESET, en: 1'b0,
				ways: WAYS_RESET, rdData: '0, rdValid: 1'b0, fault: 1'b0,
				allocValid: 1'b0, allocWays: NO_WAYS, allocInRange: 1'b0};
		end else begin
			r <= r_nxt;
		end
	end

	// Lookups and hits are never steered here, so lines in either region
	// stay visible to coherent reads; only new allocations are confined.
	assign msrRdData       = r.rdData;
	assign msrRdValid      = r.rdValid;
	assign msrFault        = r.fault;
	assign allocValid      = r.allocValid;
	assign allocWays       = r.allocWays;
	assign allocInRange    = r.allocInRange;
	assign reserveEnabled  = r.en;
	assign reservedWayBits = r.ways;

	default clocking dcb @(posedge mclk);
	endclocking
	default disable iff (rst);

	logic [PA_BITS-1:PAGE_LSB] reqPage;
	assign reqPage = reqAddr[PA_BITS-1:PAGE_LSB];

	sequence s_req_in_range;
		reqValid && reqCacheable && !reqEncrypted && r.en
			&& (reqPage >= r.low) && (reqPage <= r.high);
	endsequence

	sequence s_req_outside;
		reqValid && reqCacheable && r.en
			&& (reqEncrypted || (reqPage < r.low) || (reqPage > r.high));
	endsequence

	sequence s_disable_write;
		msrWrEn && (msrAddr == MSR_HIGH_BOUND)
			&& !(|(msrWrData & HIGH_MBZ_MASK)) && !msrWrData[EN_BIT];
	endsequence

	sequence s_ways_write;
		msrWrEn && (msrAddr == MSR_WAY_SELECT)
			&& !(|(msrWrData & WAYS_MBZ_MASK));
	endsequence

	sequence s_low_write;
		msrWrEn && (msrAddr == MSR_LOW_BOUND)
			&& !(|(msrWrData & LOW_MBZ_MASK));
	endsequence

	sequence s_high_write;
		msrWrEn && (msrAddr == MSR_HIGH_BOUND)
			&& !(|(msrWrData & HIGH_MBZ_MASK));
	endsequence

	sequence s_unmapped_read;
		msrRdEn && !msrWrEn && (msrAddr != MSR_LOW_BOUND)
			&& (msrAddr != MSR_HIGH_BOUND)
			&& (msrAddr != MSR_WAY_SELECT);
	endsequence

	property p_in_range_ways;
		logic [WAYS-1:0] w;
		(s_req_in_range, w = r.ways) |=> allocInRange && (allocWays == w);
	endproperty

	property p_outside_excl;
		logic [WAYS-1:0] w;
		(s_req_outside, w = r.ways) |=> !allocInRange
			&& ((allocWays & w) == NO_WAYS);
	endproperty

	property p_low_edge;
		reqValid && reqCacheable && !reqEncrypted && r.en
			&& (reqPage == r.low) && (r.low <= r.high) |=> allocInRange;
	endproperty

	property p_high_edge;
		reqValid && reqCacheable && !reqEncrypted && r.en
			&& (reqPage == r.high) && (r.low <= r.high) |=> allocInRange;
	endproperty

	property p_outside_qos;
		logic [WAYS-1:0] w;
		logic [WAYS-1:0] q;
		(s_req_outside, w = r.ways, q = reqQosMask)
			|=> (allocWays == (q & ~w));
	endproperty

	a_in_range_ways: assert property (p_in_range_ways)
		else $error("in-range request not confined to reserved ways");

	a_outside_excl: assert property (p_outside_excl)
		else $error("out-of-range request allocated into reserved way");

	a_low_bound_incl: assert property (p_low_edge)
		else $error("low bound page not treated as in range");

	a_high_bound_incl: assert property (p_high_edge)
		else $error("high bound page not treated as in range");

	a_uncached_none: assert property (
		reqValid && !reqCacheable |=> allocValid && (allocWays == NO_WAYS))
		else $error("uncacheable request given allocation ways");

	a_encrypt_skip: assert property (
		reqValid && reqEncrypted |=> !allocInRange)
		else $error("encrypted address treated as reserved");

	a_disable_off: assert property (
		s_disable_write ##1 !msrWrEn
			##1 (!msrWrEn && reqValid && reqCacheable)
		|=> !reserveEnabled && !allocInRange
			&& (allocWays == $past(reqQosMask)))
		else $error("enable clear did not lift restriction");

	a_no_fill: assert property (
		allocValid |-> $past(reqValid))
		else $error("allocation without a request");

	a_ways_store: assert property (
		s_ways_write |=> (reservedWayBits == $past(msrWrData[WAYS-1:0]))
			&& !msrFault)
		else $error("way select write not stored");

	a_high_readback: assert property (
		msrRdEn && !msrWrEn && (msrAddr == MSR_HIGH_BOUND)
		|=> msrRdValid && (msrRdData[EN_BIT] == reserveEnabled)
			&& (msrRdData[PA_BITS-1:PAGE_LSB] == r.high))
		else $error("high bound readback wrong");

	a_mbz_fault: assert property (
		msrWrEn && (msrAddr == MSR_LOW_BOUND)
			&& (|(msrWrData & LOW_MBZ_MASK))
		|=> msrFault && (r.low == $past(r.low)))
		else $error("reserved bits in low bound accepted");

	a_disabled_qos: assert property (
		reqValid && reqCacheable && !r.en
		|=> (allocWays == $past(reqQosMask)) && !allocInRange)
		else $error("restriction applied while disabled");

	a_low_store: assert property (
		s_low_write |=> !msrFault
			&& (r.low == $past(msrWrData[PA_BITS-1:PAGE_LSB])))
		else $error("low bound write not stored");

	a_high_store: assert property (
		s_high_write |=> !msrFault
			&& (reserveEnabled == $past(msrWrData[EN_BIT]))
			&& (r.high == $past(msrWrData[PA_BITS-1:PAGE_LSB])))
		else $error("high bound write not stored");

	a_low_readback: assert property (
		msrRdEn && !msrWrEn && (msrAddr == MSR_LOW_BOUND)
		|=> msrRdValid && (msrRdData[PA_BITS-1:PAGE_LSB] == r.low))
		else $error("low bound readback wrong");

	a_unmapped_read: assert property (
		s_unmapped_read |=> msrFault && !msrRdValid
			&& (msrRdData == '0))
		else $error("unmapped register read not refused");

	a_outside_qos: assert property (p_outside_qos)
		else $error("out-of-range ways differ from QoS minus reserved");

	a_idle_quiet: assert property (
		!reqValid |=> !allocValid && (allocWays == NO_WAYS)
			&& !allocInRange)
		else $error("allocation answer without a request");

	a_disabled_out: assert property (
		reqValid && !r.en |=> !allocInRange)
		else $error("range flag set while disabled");

	a_repeat_reinstall: assert property (
		s_req_in_range ##1 s_req_in_range |=> allocInRange)
		else $error("repeat in-range access not placed in reserved ways");
endmodule

//--- core/l3rr_pkg.sv
// Constants and types for the cache way-reservation block
// Function
// - Way-select bit n set gives way n to in-range lines; field is W-1:0.
// - Page P-1:12 within low..high, both bounds inclusive, is in range.
// - Selected ways are the reserved region; the rest are unreserved.
// - Writing zero to the enable bit switches reservation off.
// - A range smaller than the selected ways stays resident, coherent.
// - An oversized range is replaced normally within selected ways only.
// - Out-of-range lines never allocate into any reserved way.
// - Enabling fills nothing; ways fill only on real accesses.
// - While enabled, in-range lines go reserved, others go unreserved.
// - Lines in the wrong region still return current data coherently.
// - Each shared cache instance has its own independent configuration.
// - Reservation never makes uncacheable addresses cacheable.
// - Modified in-range lines re-install in reserved ways, no re-enable.
// - Encrypted physical addresses are never subject to reservation.
// - Reserved ways are removed from quality-of-service way masks.
// - High bound holds address P-1:12 and enable bit 0; low bound holds only P-1:12, bit 0 reserved.
package l3rr_pkg;
	localparam int PA_BITS  = 48;
	localparam int WAYS     = 16;
	localparam int PAGE_LSB = 12;
	localparam int EN_BIT   = 0;

	localparam logic [31:0] MSR_LOW_BOUND  = 32'hC001_1095;
	localparam logic [31:0] MSR_HIGH_BOUND = 32'hC001_1096;
	localparam logic [31:0] MSR_WAY_SELECT = 32'hC001_109A;

	localparam logic [63:0] LOW_MBZ_MASK  = 64'hFFFF_0000_0000_0FFF;
	localparam logic [63:0] HIGH_MBZ_MASK = 64'hFFFF_0000_0000_0FFE;
	localparam logic [63:0] WAYS_MBZ_MASK = 64'hFFFF_FFFF_FFFF_0000;

	localparam logic [PA_BITS-1:PAGE_LSB] BOUND_RESET = '0;
	localparam logic [WAYS-1:0]           WAYS_RESET  = '0;
	localparam logic [WAYS-1:0]           NO_WAYS     = '0;

	typedef enum {SEL_NONE, SEL_LOW, SEL_HIGH, SEL_WAYS} l3rr_sel_type;

	typedef struct packed {
		logic [PA_BITS-1:PAGE_LSB] low;
		logic [PA_BITS-1:PAGE_LSB] high;
		logic                      en;
		logic [WAYS-1:0]           ways;
		logic [63:0]               rdData;
		logic                      rdValid;
		logic                      fault;
		logic                      allocValid;
		logic [WAYS-1:0]           allocWays;
		logic                      allocInRange;
	} l3rr_state_type;
endpackage

//--- core/l3rr_cfg_if.sv
// Configuration and per-request signals shared inside the block
`timescale 1ns/100ps
interface l3rr_cfg_if
	import l3rr_pkg::*;
();
	logic                      en;
	logic [PA_BITS-1:PAGE_LSB] low;
	logic [PA_BITS-1:PAGE_LSB] high;
	logic [WAYS-1:0]           ways;
	logic [PA_BITS-1:PAGE_LSB] addrField;
	logic                      encrypted;
	logic                      cacheable;
	logic [WAYS-1:0]           qosMask;
	logic                      inRange;
	logic [WAYS-1:0]           allowWays;

	modport ctl (output en, low, high, ways, addrField, encrypted,
		cacheable, qosMask, input inRange, allowWays);
	modport cmp (input en, low, high, addrField, encrypted,
		output inRange);
	modport filt (input en, ways, cacheable, qosMask, inRange,
		output allowWays);
endinterface

//--- core/l3rr_range_cmp.sv
// Inclusive page-granular range compare
`timescale 1ns/100ps
module l3rr_range_cmp
	import l3rr_pkg::*;
(
	l3rr_cfg_if.cmp cfg
);
	always_comb begin
		cfg.inRange = cfg.en && !cfg.encrypted
			&& (cfg.addrField >= cfg.low)
			&& (cfg.addrField <= cfg.high);
	end
endmodule

//--- core/l3rr_way_filter.sv
// Allocation way mask per request region
`timescale 1ns/100ps
module l3rr_way_filter
	import l3rr_pkg::*;
(
	l3rr_cfg_if.filt cfg
);
	always_comb begin
		if (!cfg.cacheable) begin
			cfg.allowWays = NO_WAYS;
		end else if (!cfg.en) begin
			cfg.allowWays = cfg.qosMask;
		end else if (cfg.inRange) begin
			cfg.allowWays = cfg.ways;
		end else begin
			// Reserved ways dropped from the unreserved set and QoS mask
			cfg.allowWays = cfg.qosMask & ~cfg.ways;
		end
	end
endmodule

//--- dv/l3rr_core_model.sv
// Core-side requester that issues allocation requests to the block
`timescale 1ns/100ps
module l3rr_core_model
	import l3rr_pkg::*;
(
	input  wire logic               mclk,
	output logic                    reqValid,
	output logic      [PA_BITS-1:0] reqAddr,
	output logic                    reqCacheable,
	output logic                    reqEncrypted,
	output logic      [WAYS-1:0]    reqQosMask
);
	initial begin
		reqValid = 1'b0;
		reqAddr = '0;
		reqCacheable = 1'b0;
		reqEncrypted = 1'b0;
		reqQosMask = '0;
	end

	// One request per call, entered at a falling edge
	task automatic send(input logic [PA_BITS-1:0] a, input logic c,
		input logic e, input logic [WAYS-1:0] q, input logic last);
		reqValid = 1'b1;
		reqAddr = a;
		reqCacheable = c;
		reqEncrypted = e;
		reqQosMask = q;
		@(negedge mclk);
		if (last) begin
			// Idle address, cacheable and QoS lines carry no stale copy of the last request
			reqValid = 1'b0;
			reqAddr = ~reqAddr;
			reqCacheable = ~reqCacheable;
			reqQosMask = ~reqQosMask;
		end
	endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for the cache way-reservation block
`timescale 1ns/100ps
module tb
	import l3rr_pkg::*;
;
	localparam logic [63:0] LOW_VAL  = 64'h0000_0000_0010_0000;
	localparam logic [63:0] HIGH_EN  = 64'h0000_0000_0010_F001;
	localparam logic [63:0] HIGH_OFF = 64'h0000_0000_0010_F000;
	localparam logic [63:0] WAY_VAL  = 64'h0000_0000_0000_00FF;
	logic               mclk = 1'b0;
	logic               rst = 1'b1;
	logic               msrWrEn = 1'b0;
	logic               msrRdEn = 1'b0;
	logic [31:0]        msrAddr = '0;
	logic [63:0]        msrWrData = '0;
	logic [63:0]        msrRdData;
	logic               msrRdValid, msrFault;
	logic               reqValid, reqCacheable, reqEncrypted;
	logic [PA_BITS-1:0] reqAddr;
	logic [WAYS-1:0]    reqQosMask, allocWays, reservedWayBits;
	logic               allocValid, allocInRange, reserveEnabled;
	int                 n_errors = 0;
	int                 comparisons = 0;

	always #2.5 mclk = ~mclk;

	l3rr_core_model model (.mclk(mclk), .reqValid(reqValid),
		.reqAddr(reqAddr), .reqCacheable(reqCacheable),
		.reqEncrypted(reqEncrypted), .reqQosMask(reqQosMask));

	l3rr_way_reserve DUT (.mclk(mclk), .rst(rst), .msrWrEn(msrWrEn),
		.msrRdEn(msrRdEn), .msrAddr(msrAddr), .msrWrData(msrWrData),
		.msrRdData(msrRdData), .msrRdValid(msrRdValid),
		.msrFault(msrFault), .reqValid(reqValid), .reqAddr(reqAddr),
		.reqCacheable(reqCacheable), .reqEncrypted(reqEncrypted),
		.reqQosMask(reqQosMask), .allocValid(allocValid),
		.allocWays(allocWays), .allocInRange(allocInRange),
		.reserveEnabled(reserveEnabled),
		.reservedWayBits(reservedWayBits));

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [63:0] d,
		input logic f);
		msrAddr = a;
		msrWrData = d;
		msrWrEn = 1'b1;
		@(negedge mclk);
		msrWrEn = 1'b0;
		check(msrFault, f);
		// Let an edge pass so the next call never re-raises in this step
		@(negedge mclk);
	endtask

	task automatic rd(input logic [31:0] a, input logic [63:0] d,
		input logic f);
		msrAddr = a;
		msrRdEn = 1'b1;
		@(negedge mclk);
		msrRdEn = 1'b0;
		check(msrRdValid, !f);
		check(msrFault, f);
		check(msrRdData, d);
		@(negedge mclk);
	endtask

	// Request, then check the answer; ci selects the range flag check
	task automatic rq(input logic [PA_BITS-1:0] a, input logic c,
		input logic e, input logic [WAYS-1:0] q, input logic last,
		input logic [WAYS-1:0] w, input logic ci, input logic i);
		model.send(a, c, e, q, last);
		check(allocValid, 1'b1);
		check(allocWays, w);
		if (ci)
			check(allocInRange, i);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		#(5 * 2000);
		n_errors++;
		wrap_up();
	end

	initial begin
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		rd(MSR_LOW_BOUND, '0, 1'b0);
		rd(MSR_HIGH_BOUND, '0, 1'b0);
		rd(MSR_WAY_SELECT, '0, 1'b0);
		rq(48'h0000_0010_0000, 1'b1, 1'b0, 16'hFFFF, 1'b1, 16'hFFFF,
			1'b0, 1'b0);
		$display("test reset done");
		// No traffic in flight while configuring
		wr(MSR_WAY_SELECT, WAY_VAL, 1'b0);
		wr(MSR_LOW_BOUND, LOW_VAL, 1'b0);
		wr(MSR_HIGH_BOUND, HIGH_EN, 1'b0);
		check(allocValid, 1'b0);
		check(reserveEnabled, 1'b1);
		check(reservedWayBits, WAY_VAL);
		rd(MSR_HIGH_BOUND, HIGH_EN, 1'b0);
		wr(MSR_LOW_BOUND, LOW_VAL | 64'h1, 1'b1);
		wr(MSR_WAY_SELECT, 64'h0000_0000_0001_0000, 1'b1);
		rd(MSR_LOW_BOUND, LOW_VAL, 1'b0);
		rd(32'hC001_1097, '0, 1'b1);
		$display("test config done");
		rq(48'h0000_0010_0000, 1'b1, 1'b0, 16'hFFFF, 1'b0, 16'h00FF,
			1'b1, 1'b1);
		rq(48'h0000_0010_FFFF, 1'b1, 1'b0, 16'hFFFF, 1'b0, 16'h00FF,
			1'b1, 1'b1);
		rq(48'h0000_000F_FFFF, 1'b1, 1'b0, 16'hFFFF, 1'b0, 16'hFF00,
			1'b1, 1'b0);
		rq(48'h0000_0011_0000, 1'b1, 1'b0, 16'h0FF0, 1'b0, 16'h0F00,
			1'b1, 1'b0);
		rq(48'h0000_0010_8000, 1'b1, 1'b0, 16'h0FF0, 1'b0, 16'h00FF,
			1'b1, 1'b1);
		rq(48'h0000_0010_4000, 1'b0, 1'b0, 16'hFFFF, 1'b0, 16'h0000,
			1'b0, 1'b0);
		rq(48'h0000_0010_4000, 1'b1, 1'b1, 16'hFFFF, 1'b1, 16'hFF00,
			1'b1, 1'b0);
		@(negedge mclk);
		check(allocValid, 1'b0);
		rq(48'h0000_0010_4000, 1'b1, 1'b0, 16'hFFFF, 1'b1, 16'h00FF,
			1'b1, 1'b1);
		$display("test steering done");
		wr(MSR_HIGH_BOUND, HIGH_OFF, 1'b0);
		check(reserveEnabled, 1'b0);
		rq(48'h0000_0010_4000, 1'b1, 1'b0, 16'h0FF0, 1'b1, 16'h0FF0,
			1'b0, 1'b0);
		$display("test disable done");
		wrap_up();
	end
endmodule
